// File: irc_consts.svh
// constants for the infrared pulse codec and its serial transceiver partner
`ifndef IRC_CONSTS_SVH
`define IRC_CONSTS_SVH

`define IRC_ADDR_W        8
`define IRC_REG_CTRL      8'h00
`define IRC_REG_TXPL      8'h01
`define IRC_REG_RXFL      8'h02
`define IRC_RST_VAL       8'h00
`define IRC_CTRL_MASK     8'h0f
`define IRC_EVENT_CHANNEL_SELECT_ON_BIT  3
`define IRC_EVENT_CHANNEL_SELECT_CH_HI   2
`define IRC_TXPL_316      8'h00
`define IRC_TXPL_OFF      8'hff
`define IRC_316_TICKS     8'h03
`define IRC_BIT_TICKS     5'h10
`define IRC_BIT_TICKS_2X  5'h08
`define IRC_CNT_ZERO8     8'h00
`define IRC_CNT_ZERO5     5'h00
`define IRC_CNT_ONE8      8'h01
`define IRC_CNT_ONE5      5'h01
`define IRC_CNT_MAX8      8'hff

`endif

// File: irc_pkg.sv
// types shared by the infrared pulse codec and its serial transceiver partner
package irc_pkg;

    typedef enum logic [1:0] {
        IRC_CM_ASYNC = 2'b00,
        IRC_CM_SYNC  = 2'b01,
        IRC_CM_IR    = 2'b10,
        IRC_CM_MSPI  = 2'b11
    } irc_comm_mode_select_e;

    typedef enum logic [1:0] {
        IRC_TX_316   = 2'b00,
        IRC_TX_FIXED = 2'b01,
        IRC_TX_RAW   = 2'b10
    } irc_tx_scheme_e;

endpackage

// File: irc_link_if.sv
// link between the serial transceiver and the infrared pulse codec
`timescale 1ns/10ps
`default_nettype none
interface irc_link_if
    import irc_pkg::*;
();
    irc_comm_mode_select_e comm_mode_select;
    logic       double_speed;
    logic       transmitter_enable;
    logic       receiver_enable;
    logic       x16_tick;
    logic       bit_start;
    logic       txd;
    logic       rxd;

    modport codec
    (
        input  comm_mode_select,
        input  double_speed,
        input  transmitter_enable,
        input  receiver_enable,
        input  x16_tick,
        input  bit_start,
        input  txd,
        output rxd
    );

    modport xcvr
    (
        output comm_mode_select,
        output double_speed,
        output transmitter_enable,
        output receiver_enable,
        output x16_tick,
        output bit_start,
        output txd,
        input  rxd
    );
endinterface
`default_nettype wire

// File: irc_xcvr.sv
// serial transceiver end: baud timing, bit framing and mode towards the codec
`timescale 1ns/10ps
`default_nettype none
`include "irc_consts.svh"
module irc_xcvr
    import irc_pkg::*;
#(
    parameter int unsigned BAUD_DIV = 4
)
(
    input  wire logic   clock,
    input  wire logic   rst_n,
    irc_link_if.xcvr    link,
    input  wire logic   mode_ir,
    input  wire logic   double_speed_req,
    input  wire logic   tx_enable_req,
    input  wire logic   rx_enable_req,
    input  wire logic   tx_bit,
    output logic        rx_bit
);
    localparam int unsigned DW = (BAUD_DIV > 1) ? $clog2(BAUD_DIV) : 1;

    logic [DW-1:0] div_q;
    logic [4:0]    tick_cnt_q;
    logic          tick_q;
    logic          bstart_q;
    logic          txd_q;
    logic          rx_q;
    logic [4:0]    bit_len;

    // double speed is refused while infrared is selected
    assign bit_len = (link.double_speed && !mode_ir) ? `IRC_BIT_TICKS_2X : `IRC_BIT_TICKS;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            div_q  <= '0;
            tick_q <= 1'b0;
        end
        else
        begin
            tick_q <= (div_q == DW'(BAUD_DIV - 1));
            div_q  <= (div_q == DW'(BAUD_DIV - 1)) ? '0 : div_q + DW'(1);
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tick_cnt_q <= `IRC_CNT_ZERO5;
            bstart_q   <= 1'b0;
            txd_q      <= 1'b1;
        end
        else
        begin
            bstart_q <= 1'b0;
            if (tick_q)
            begin
                if (tick_cnt_q >= bit_len - `IRC_CNT_ONE5)
                begin
                    tick_cnt_q <= `IRC_CNT_ZERO5;
                    bstart_q   <= 1'b1;
                    txd_q      <= tx_enable_req ? tx_bit : 1'b1;
                end
                else
                begin
                    tick_cnt_q <= tick_cnt_q + `IRC_CNT_ONE5;
                end
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            rx_q <= 1'b1;
        else
            rx_q <= rx_enable_req ? link.rxd : 1'b1;
    end

    // one transceiver only ever drives the infrared mode here
    assign link.comm_mode_select   = mode_ir ? IRC_CM_IR : IRC_CM_ASYNC;
    assign link.double_speed       = double_speed_req && !mode_ir;
    assign link.transmitter_enable = tx_enable_req;
    assign link.receiver_enable    = rx_enable_req;
    assign link.x16_tick           = tick_q;
    assign link.bit_start          = bstart_q;
    assign link.txd                = txd_q;
    assign rx_bit                  = rx_q;
endmodule
`default_nettype wire

// File: irc_codec.sv
// infrared pulse codec: registers, transmit pulse shaping, receive filter and decode
//
// Function
// - infrared mode routes transceiver signals through codec
// - pin levels are inverse of infrared pulse
// - chosen event channel replaces receive pin
// - setting zero gives three-sixteenths bit pulse
// - settings 1..254 give that many clocks
// - fixed pulse starts at baud clock edge
// - setting 255 passes both directions unchanged
// - pulse and filter settings inert unless infrared mode selected; event channel selection acts in every mode
// - software sets pulse length before transmitter
// - filter zero accepts pulses unfiltered
// - filter x needs x+1 equal samples
// - short pulse dropped, reads as one
// - software sets filter before enabling receiver
// - only one transceiver selects infrared mode
// - event field: 0000 none, 1nnn channel nnn
// - control upper four bits read zero
// - mode field 10 selects infrared operation
// - double speed kept clear in infrared mode
`timescale 1ns/10ps
`default_nettype none
`include "irc_consts.svh"
module irc_codec
    import irc_pkg::*;
#(
    parameter int unsigned EV_CHANNELS = 8
)
(
    input  wire logic                   clock,
    input  wire logic                   rst_n,
    irc_link_if.codec                   link,
    input  wire logic [`IRC_ADDR_W-1:0] reg_addr,
    input  wire logic [7:0]             reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic [7:0]                  reg_rdata,
    input  wire logic                   rx_pin,
    input  wire logic [EV_CHANNELS-1:0] event_ch,
    output logic                        tx_pin
);
    logic [7:0]     ctrl_q;
    logic [7:0]     txpl_q;
    logic [7:0]     rxfl_q;
    logic [7:0]     rdata_q;
    logic           ir_mode;
    logic           bypass;
    irc_tx_scheme_e scheme;
    logic [7:0]     tx_cnt_q;
    logic [7:0]     tx_cnt_d;
    logic           tx_pin_q;
    logic           rx_src;
    logic           rx_pulse_q;
    logic           rx_last_q;
    logic [7:0]     eq_cnt_q;
    logic [7:0]     eq_cnt_d;
    logic           filt_q;
    logic           filt_d;
    logic [4:0]     hold_q;
    logic [4:0]     hold_d;
    logic           rxd_q;

    // register file
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_q <= `IRC_RST_VAL;
            txpl_q <= `IRC_RST_VAL;
            rxfl_q <= `IRC_RST_VAL;
        end
        else if (reg_wr)
        begin
            unique case (reg_addr)
                `IRC_REG_CTRL: ctrl_q <= reg_wdata & `IRC_CTRL_MASK;
                `IRC_REG_TXPL: txpl_q <= reg_wdata;
                `IRC_REG_RXFL: rxfl_q <= reg_wdata;
                default:       ;
            endcase
        end
    end

    // read data stands the cycle after the strobe only
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            rdata_q <= `IRC_RST_VAL;
        else if (reg_rd)
        begin
            unique case (reg_addr)
                `IRC_REG_CTRL: rdata_q <= ctrl_q & `IRC_CTRL_MASK;
                `IRC_REG_TXPL: rdata_q <= txpl_q;
                `IRC_REG_RXFL: rdata_q <= rxfl_q;
                default:       rdata_q <= `IRC_RST_VAL;
            endcase
        end
        else
            rdata_q <= `IRC_RST_VAL;
    end

    assign ir_mode = (link.comm_mode_select == IRC_CM_IR);
    // outside infrared mode only the event channel selection still acts, on the receive signal
    assign bypass  = !ir_mode || (txpl_q == `IRC_TXPL_OFF);

    always_comb
    begin
        if (txpl_q == `IRC_TXPL_316)
            scheme = IRC_TX_316;
        else if (txpl_q == `IRC_TXPL_OFF)
            scheme = IRC_TX_RAW;
        else
            scheme = IRC_TX_FIXED;
    end

    // transmit: a zero bit becomes one pulse counted from the bit start
    always_comb
    begin
        tx_cnt_d = tx_cnt_q;
        if (link.bit_start && !link.txd)
        begin
            unique case (scheme)
                IRC_TX_316:   tx_cnt_d = `IRC_316_TICKS;
                IRC_TX_FIXED: tx_cnt_d = txpl_q;
                IRC_TX_RAW:   tx_cnt_d = `IRC_CNT_ZERO8;
                default:      tx_cnt_d = `IRC_CNT_ZERO8;
            endcase
        end
        else if (link.bit_start)
            tx_cnt_d = `IRC_CNT_ZERO8;
        else if (tx_cnt_q != `IRC_CNT_ZERO8)
        begin
            // 3/16 counts oversampling ticks, fixed length counts clocks
            if (scheme == IRC_TX_FIXED || link.x16_tick)
                tx_cnt_d = tx_cnt_q - `IRC_CNT_ONE8;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            tx_cnt_q <= `IRC_CNT_ZERO8;
        else
            tx_cnt_q <= bypass ? `IRC_CNT_ZERO8 : tx_cnt_d;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            tx_pin_q <= 1'b1;
        else if (bypass)
            tx_pin_q <= link.txd;
        else
            // 3/16 starts a clock after its tick, so the clock of the last tick stays low too
            tx_pin_q <= !(tx_cnt_d != `IRC_CNT_ZERO8 ||
                          (scheme == IRC_TX_316 && tx_cnt_q != `IRC_CNT_ZERO8));
    end

    // receive source: event channel replaces the pin when selected
    always_comb
    begin
        if (ctrl_q[`IRC_EVENT_CHANNEL_SELECT_ON_BIT])
            rx_src = event_ch[ctrl_q[`IRC_EVENT_CHANNEL_SELECT_CH_HI:0]];
        else
            rx_src = rx_pin;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_pulse_q <= 1'b0;
            rx_last_q  <= 1'b0;
        end
        else
        begin
            rx_pulse_q <= !rx_src;
            rx_last_q  <= rx_pulse_q;
        end
    end

    // consecutive equal samples, saturating so long runs stay accepted
    always_comb
    begin
        if (rx_pulse_q != rx_last_q)
            eq_cnt_d = `IRC_CNT_ZERO8;
        else if (eq_cnt_q != `IRC_CNT_MAX8)
            eq_cnt_d = eq_cnt_q + `IRC_CNT_ONE8;
        else
            eq_cnt_d = eq_cnt_q;
        if (rxfl_q == `IRC_CNT_ZERO8 || eq_cnt_d >= rxfl_q)
            filt_d = rx_pulse_q;
        else
            filt_d = filt_q;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            eq_cnt_q <= `IRC_CNT_ZERO8;
            filt_q   <= 1'b0;
        end
        else
        begin
            eq_cnt_q <= eq_cnt_d;
            filt_q   <= ir_mode ? filt_d : 1'b0;
        end
    end

    // an accepted pulse holds zero for one bit period of ticks
    always_comb
    begin
        hold_d = hold_q;
        if (filt_d && !filt_q)
            hold_d = `IRC_BIT_TICKS;
        else if (link.x16_tick && hold_q != `IRC_CNT_ZERO5)
            hold_d = hold_q - `IRC_CNT_ONE5;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            hold_q <= `IRC_CNT_ZERO5;
        else
            hold_q <= bypass ? `IRC_CNT_ZERO5 : hold_d;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            rxd_q <= 1'b1;
        else if (bypass)
            rxd_q <= rx_src;
        else
            rxd_q <= (hold_d == `IRC_CNT_ZERO5);
    end

    assign link.rxd  = rxd_q;
    assign tx_pin    = tx_pin_q;
    assign reg_rdata = rdata_q;
endmodule
`default_nettype wire

// File: irc_codec_assertions.sv
// assertions on the link between the serial transceiver and the codec
`timescale 1ns/10ps
`default_nettype none
module irc_link_chk
    import irc_pkg::*;
#(
    parameter int unsigned BAUD_DIV = 4
)
(
    input wire logic       clock,
    input wire logic       rst_n,
    input wire irc_comm_mode_select_e comm_mode_select,
    input wire logic       double_speed,
    input wire logic       transmitter_enable,
    input wire logic       x16_tick,
    input wire logic       bit_start,
    input wire logic       txd,
    input wire logic       rxd
);
    logic [7:0] gap_q;
    logic       tsn_q;
    logic [4:0] tk_q;
    logic       bsn_q;

    // first tick and first bit after reset have no reference, hence the seen flags
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gap_q <= 8'h00;
            tsn_q <= 1'b0;
        end
        else
        begin
            gap_q <= x16_tick ? 8'h00 : gap_q + 8'h01;
            tsn_q <= tsn_q | x16_tick;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tk_q  <= 5'h00;
            bsn_q <= 1'b0;
        end
        else
        begin
            tk_q  <= bit_start ? 5'h00 : tk_q + 5'(x16_tick);
            bsn_q <= bsn_q | bit_start;
        end
    end

    default clocking dc @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    a_no_double_ir: assert property (comm_mode_select == IRC_CM_IR |-> !double_speed)
        else $error("double speed set in infrared mode");
    a_mode_legal: assert property (comm_mode_select inside {IRC_CM_IR, IRC_CM_ASYNC})
        else $error("unexpected communication mode");
    a_tick_pulse: assert property (x16_tick |=> !x16_tick)
        else $error("tick longer than one cycle");
    a_tick_spacing: assert property (x16_tick && tsn_q |-> gap_q == 8'(BAUD_DIV - 1))
        else $error("tick spacing wrong");
    a_bit_spacing: assert property (bit_start && bsn_q && !double_speed |->
        (tk_q + 5'(x16_tick)) == 5'h10)
        else $error("bit period not sixteen ticks");
    a_txd_off_idle: assert property (bit_start && !$past(transmitter_enable) |-> txd)
        else $error("txd low with transmitter disabled");
    a_bit_pulse: assert property (bit_start |=> (!bit_start) [*8])
        else $error("bit start repeated too soon");
    a_txd_framed: assert property ($changed(txd) |-> bit_start)
        else $error("txd changed outside bit start");
    a_idle_high: assert property ($rose(rst_n) |-> rxd && txd)
        else $error("link not idle high after reset");
endmodule
`default_nettype wire

// File: irc_codec_bench.sv
// testbench: transceiver and codec joined over the link, driven from both sides
`timescale 1ns/10ps
`default_nettype none
`include "irc_consts.svh"
module irc_codec_bench;
    localparam int BD = 4;
    logic       clock;
    logic       rst_n;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    logic       rx_pin;
    logic [7:0] event_ch;
    logic       tx_pin;
    logic       mode_ir;
    logic       dbl;
    logic       tx_en;
    logic       rx_en;
    logic       tx_bit;
    logic       rx_bit;
    int         err_total;
    int         checks;
    int         cyc;

    irc_link_if irc_link_if_i ();
    irc_xcvr #(.BAUD_DIV(BD)) irc_xcvr_i (.clock(clock), .rst_n(rst_n), .link(irc_link_if_i),
        .mode_ir(mode_ir), .double_speed_req(dbl), .tx_enable_req(tx_en),
        .rx_enable_req(rx_en), .tx_bit(tx_bit), .rx_bit(rx_bit));
    irc_codec irc_codec_i (.clock(clock), .rst_n(rst_n), .link(irc_link_if_i),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .rx_pin(rx_pin), .event_ch(event_ch), .tx_pin(tx_pin));
    irc_link_chk #(.BAUD_DIV(BD)) irc_link_chk_i (.clock(clock), .rst_n(rst_n),
        .comm_mode_select(irc_link_if_i.comm_mode_select),
        .double_speed(irc_link_if_i.double_speed),
        .transmitter_enable(irc_link_if_i.transmitter_enable),
        .x16_tick(irc_link_if_i.x16_tick),
        .bit_start(irc_link_if_i.bit_start), .txd(irc_link_if_i.txd), .rxd(irc_link_if_i.rxd));

    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    task automatic close_out();
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // run is under two thousand cycles; the ceiling leaves wide margin
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            close_out();
        end
    end

    task automatic cmp(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value %s expected %0h seen %0h", nm, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock);
        reg_rd   <= 1'b0;
        #1;
        cmp("reg_rdata", 16'(e), 16'(reg_rdata));
    endtask

    // enables drop while the lengths change, as software must do
    task automatic cfg(input logic [7:0] txpl, input logic [7:0] rxfl);
        tx_en <= 1'b0;
        rx_en <= 1'b0;
        wr(`IRC_REG_TXPL, txpl);
        wr(`IRC_REG_RXFL, rxfl);
        tx_en <= 1'b1;
        rx_en <= 1'b1;
    endtask

    task automatic tx_case(input int exp);
        int n;
        int len;
        n = 0;
        len = 0;
        do
        begin
            @(posedge clock);
            #1;
            n++;
        end
        while (!(irc_link_if_i.bit_start === 1'b1 && irc_link_if_i.txd === 1'b0) && n < 300);
        @(posedge clock);
        #1;
        while (tx_pin === 1'b0 && len < 300)
        begin
            len++;
            @(posedge clock);
            #1;
        end
        cmp("tx_low", 16'(exp), 16'(len));
    endtask

    // txd is taken once it has settled, never in the edge that may move it
    task automatic follow(input string nm);
        logic p;
        #1;
        p = irc_link_if_i.txd;
        for (int i = 0; i < 96; i++)
        begin
            @(posedge clock);
            if (i % 24 == 0)
                tx_bit <= ~tx_bit;
            #1;
            cmp(nm, 16'(p), 16'(tx_pin));
            p = irc_link_if_i.txd;
        end
        @(posedge clock);
        tx_bit <= 1'b0;
    endtask

    function automatic logic fits(input int kind, input int len, input int low);
        return (kind == 0) ? (low == 0) : (kind == 1) ? (low >= 15 * BD && low <= 16 * BD + 1)
            : (low == len);
    endfunction

    // kind 0 rejected, 1 accepted and held a bit period, 2 passed through unchanged
    task automatic rx_case(input int src, input int len, input int kind);
        int low;
        int lowb;
        low = 0;
        lowb = 0;
        for (int k = 0; k < 16 * BD + 30; k++)
        begin
            @(posedge clock);
            if (src > 7)
                rx_pin <= (k >= len);
            else
                event_ch[src] <= (k >= len);
            if (irc_link_if_i.rxd === 1'b0)
                low++;
            if (rx_bit === 1'b0)
                lowb++;
        end
        cmp("rxd_low", 16'h1, 16'(fits(kind, len, low)));
        cmp("rx_bit_low", 16'h1, 16'(fits(kind, len, lowb)));
    endtask

    initial
    begin
        rst_n = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        rx_pin = 1'b1;
        event_ch = 8'hff;
        mode_ir = 1'b0;
        dbl = 1'b0;
        tx_en = 1'b0;
        rx_en = 1'b0;
        tx_bit = 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        rd_chk(`IRC_REG_CTRL, `IRC_RST_VAL);
        rd_chk(`IRC_REG_TXPL, `IRC_RST_VAL);
        rd_chk(`IRC_REG_RXFL, `IRC_RST_VAL);
        cmp("tx_idle", 16'h1, 16'(tx_pin));
        wr(`IRC_REG_CTRL, 8'hff);
        rd_chk(`IRC_REG_CTRL, 8'h0f);
        wr(8'h03, 8'h5a);
        rd_chk(8'h03, 8'h00);
        wr(`IRC_REG_TXPL, 8'ha5);
        rd_chk(`IRC_REG_TXPL, 8'ha5);
        wr(`IRC_REG_RXFL, 8'h3c);
        rd_chk(`IRC_REG_RXFL, 8'h3c);
        wr(`IRC_REG_CTRL, 8'h00);
        mode_ir <= 1'b1;
        dbl <= 1'b1;
        cfg(8'h00, 8'h00);
        tx_case(3 * BD);
        cmp("double_speed", 16'h0, 16'(irc_link_if_i.double_speed));
        cfg(8'h01, 8'h00);
        tx_case(1);
        cfg(8'h28, 8'h00);
        tx_case(40);
        rx_case(8, 1, 1);
        cfg(8'h28, 8'h03);
        rx_case(8, 3, 0);
        rx_case(8, 4, 1);
        wr(`IRC_REG_CTRL, 8'h0d);
        rx_case(8, 4, 0);
        for (int ch = 0; ch < 8; ch++)
        begin
            wr(`IRC_REG_CTRL, 8'(8 + ch));
            rx_case(ch, 4, 1);
        end
        wr(`IRC_REG_CTRL, 8'h05);
        rx_case(8, 4, 1);
        wr(`IRC_REG_CTRL, 8'h00);
        cfg(8'hff, 8'h03);
        rx_case(8, 3, 2);
        follow("tx_bypass");
        dbl <= 1'b0;
        mode_ir <= 1'b0;
        cfg(8'h02, 8'h03);
        rx_case(8, 3, 2);
        follow("tx_plain");
        close_out();
    end
endmodule
`default_nettype wire
